/* design/prs_switchover.v */
// Purpose: Priority reference switchover, prescaler, feedback divider and phase path.
// Assumes: Reference samples, validity and profile table inputs are synchronous to clk.
// Notes: APB slave with zero wait states; loop filter reduced to an integrator.
//        A fresh reference preempts only past the active promoted priority.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "prs_consts.vh"

module prs_switchover #(
	parameter NREF = 4,
	parameter NPROF = 8,
	parameter ERR_W = 32
) (
	// System
	input wire clk,
	input wire rst,
	// APB slave
	input wire [15:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Reference inputs and validation results
	input wire [NREF-1:0] ref_in,
	input wire [NREF-1:0] ref_valid,
	input wire [NREF-1:0] ref_assigned,
	input wire [3*NREF-1:0] ref_profile,
	// Synthesizer feedback and tuning
	input wire synth_tick,
	output reg [ERR_W-1:0] phase_err_word,
	output reg phase_err_valid,
	output reg [ERR_W-1:0] tune_word,
	// Switchover status
	output reg [1:0] active_ref,
	output reg holdover,
	output reg switch_pulse,
	output reg buildout_pulse
);

	// Register file.
	reg [15:0] slew_rate_limit_r;
	reg [3:0] buildout_switching_control_r;
	reg [3:0] ctrl_r;
	reg [2:0] sel_prio_r [0:NPROF-1];
	reg [2:0] prom_prio_r [0:NPROF-1];
	reg [29:0] rdiv_r [0:NPROF-1];
	reg [19:0] sdiv_r [0:NPROF-1];
	reg [9:0] u_r [0:NPROF-1];
	reg [9:0] v_r [0:NPROF-1];
	reg slewing_r;

	wire [`PRS_IDX_W-1:0] idx = paddr[15:2];
	wire [2:0] pidx = idx[2:0];
	wire [`PRS_IDX_W-1:0] pbase = idx & `PRS_PROF_MASK;
	// One decode line per register; profile registers share a base.
	wire hit_slew = idx == `PRS_IDX_SLEW;
	wire hit_pbo = idx == `PRS_IDX_PBO;
	wire hit_ctrl = idx == `PRS_IDX_CTRL;
	wire hit_stat = idx == `PRS_IDX_STAT;
	wire hit_prio = pbase == `PRS_IDX_PRIO;
	wire hit_rdiv = pbase == `PRS_IDX_RDIV;
	wire hit_sdiv = pbase == `PRS_IDX_SDIV;
	wire hit_frac = pbase == `PRS_IDX_FRAC;
	wire hit_prof = hit_prio || hit_rdiv || hit_sdiv || hit_frac;
	wire hit = hit_slew || hit_pbo || hit_ctrl || hit_stat || hit_prof;
	wire acc_en = psel && penable;
	wire wr_en = acc_en && pwrite && hit;
	// Mode sits above the user reference field in the stored control bits.
	wire [1:0] mode = ctrl_r[3:2];
	wire [1:0] user_ref = ctrl_r[1:0];

	assign pready = 1'b1;
	assign pslverr = acc_en && !hit;

	// Register writes land at the access edge; unmapped writes are dropped.
	integer k;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			slew_rate_limit_r <= `PRS_SLEW_RST;
			buildout_switching_control_r <= `PRS_PBO_RST;
			ctrl_r <= `PRS_CTRL_RST;
			for (k = 0; k < NPROF; k = k + 1) begin
				sel_prio_r[k] <= `PRS_PRIO_RST;
				prom_prio_r[k] <= `PRS_PRIO_RST;
				rdiv_r[k] <= `PRS_RDIV_RST;
				sdiv_r[k] <= `PRS_SDIV_RST;
				u_r[k] <= `PRS_U_RST;
				v_r[k] <= `PRS_V_RST;
			end
		end else if (wr_en) begin
			if (hit_slew) begin
				slew_rate_limit_r <= pwdata[15:0];
			end
			if (hit_pbo) begin
				buildout_switching_control_r <= pwdata[3:0];
			end
			if (hit_ctrl) begin
				ctrl_r <= {pwdata[4:3], pwdata[1:0]};
			end
			if (hit_prio) begin
				sel_prio_r[pidx] <= pwdata[`PRS_PRIO_SEL_LSB +: 3];
				prom_prio_r[pidx] <= pwdata[`PRS_PRIO_PROM_LSB +: 3];
			end
			if (hit_rdiv) begin
				rdiv_r[pidx] <= pwdata[29:0];
			end
			if (hit_sdiv) begin
				sdiv_r[pidx] <= pwdata[19:0];
			end
			if (hit_frac) begin
				u_r[pidx] <= pwdata[9:0];
				v_r[pidx] <= pwdata[`PRS_FRAC_V_LSB +: 10];
			end
		end
	end

	// Read data is combinational and only meaningful in the access phase.
	always @* begin
		prdata = 32'h0000_0000;
		if (idx == `PRS_IDX_SLEW)
			prdata = {16'h0000, slew_rate_limit_r};
		else if (idx == `PRS_IDX_PBO)
			prdata = {28'h000_0000, buildout_switching_control_r};
		else if (idx == `PRS_IDX_CTRL)
			prdata = {27'h000_0000, ctrl_r[3:2], 1'b0, ctrl_r[1:0]};
		else if (idx == `PRS_IDX_STAT)
			prdata = {26'h000_0000, slewing_r, holdover, 2'b00, active_ref};
		else if (pbase == `PRS_IDX_PRIO)
			prdata = {25'h000_0000, prom_prio_r[pidx], 1'b0, sel_prio_r[pidx]};
		else if (pbase == `PRS_IDX_RDIV)
			prdata = {2'b00, rdiv_r[pidx]};
		else if (pbase == `PRS_IDX_SDIV)
			prdata = {12'h000, sdiv_r[pidx]};
		else if (pbase == `PRS_IDX_FRAC)
			prdata = {6'h00, v_r[pidx], 6'h00, u_r[pidx]};
	end

	// Per-reference candidate status and priorities.
	wire [NREF-1:0] cand;
	wire [3*NREF-1:0] ref_sel;
	wire [3*NREF-1:0] ref_prom;
	reg [NREF-1:0] cand_d_r;
	wire [NREF-1:0] fresh;
	genvar g;
	generate
		for (g = 0; g < NREF; g = g + 1) begin : g_ref
			wire [2:0] prof = ref_profile[3*g +: 3];
			assign cand[g] = ref_valid[g] && ref_assigned[g];
			assign ref_sel[3*g +: 3] = sel_prio_r[prof];
			assign ref_prom[3*g +: 3] = prom_prio_r[prof];
			assign fresh[g] = cand[g] && !cand_d_r[g];
		end
	endgenerate

	// Candidate history marks references that have just become valid.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cand_d_r <= {NREF{1'b0}};
		end else begin
			cand_d_r <= cand;
		end
	end

	// Best candidate by selection priority; descending scan lets low index win ties.
	reg [1:0] best_ref;
	reg best_ok;
	integer i;
	always @* begin
		best_ref = 2'd0;
		best_ok = 1'b0;
		for (i = NREF - 1; i >= 0; i = i - 1) begin
			if (cand[i] && (!best_ok || ref_sel[3*i +: 3] <= ref_sel[3*best_ref +: 3])) begin
				best_ref = i[1:0];
				best_ok = 1'b1;
			end
		end
	end

	// Target reference, evaluated every cycle.
	wire act_ok = !holdover && cand[active_ref];
	wire [2:0] act_prom = ref_prom[3*active_ref +: 3];
	reg preempt;
	integer j;
	// A fresh reference preempts only if it beats the promoted priority.
	always @* begin
		preempt = 1'b0;
		for (j = 0; j < NREF; j = j + 1) begin
			if (fresh[j] && ref_sel[3*j +: 3] < act_prom) begin
				preempt = 1'b1;
			end
		end
	end

	reg [1:0] tgt_ref;
	reg tgt_hold;
	always @* begin
		tgt_ref = active_ref;
		tgt_hold = holdover;
		case (mode)
			`PRS_MODE_AUTO, `PRS_MODE_FALLBACK: begin
				if (mode == `PRS_MODE_FALLBACK && cand[user_ref]) begin
					tgt_ref = user_ref;
					tgt_hold = 1'b0;
				end else if (!act_ok) begin
					tgt_ref = best_ref;
					tgt_hold = !best_ok;
				end else if (preempt && best_ok && ref_sel[3*best_ref +: 3] < act_prom) begin
					tgt_ref = best_ref;
					tgt_hold = 1'b0;
				end
			end
			`PRS_MODE_HOLDOVER: begin
				tgt_ref = user_ref;
				tgt_hold = !cand[user_ref];
			end
			`PRS_MODE_MANUAL: begin
				tgt_ref = user_ref;
				tgt_hold = 1'b0;
			end
			default: begin
				tgt_hold = 1'b1;
			end
		endcase
	end

	wire do_switch = !tgt_hold && (holdover || tgt_ref != active_ref);
	wire [2:0] new_sel = ref_sel[3*tgt_ref +: 3];
	wire new_main = {1'b0, new_sel} < buildout_switching_control_r;
	wire [2:0] act_prof = ref_profile[3*active_ref +: 3];

	// Pulses mark the cycle in which the new selection takes effect.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			active_ref <= 2'd0;
			holdover <= 1'b1;
			switch_pulse <= 1'b0;
			buildout_pulse <= 1'b0;
		end else begin
			active_ref <= tgt_ref;
			holdover <= tgt_hold;
			switch_pulse <= do_switch;
			buildout_pulse <= do_switch && !new_main;
		end
	end

	// Prescaler on the active reference, feedback divider on synthesizer ticks.
	reg ref_d_r;
	reg [29:0] rcnt_r;
	reg [20:0] fcnt_r;
	reg [9:0] facc_r;
	reg [31:0] time_r;
	reg [31:0] tref_r;
	reg ref_pulse_r;
	wire ref_rise = ref_in[active_ref] && !ref_d_r && !holdover;
	wire [10:0] facc_sum = {1'b0, facc_r} + {1'b0, u_r[act_prof]};
	wire fcarry = facc_sum >= {1'b0, v_r[act_prof]};
	wire [20:0] fterm = {1'b0, sdiv_r[act_prof]} + {20'h0_0000, fcarry};
	wire fb_pulse = synth_tick && (fcnt_r >= fterm);

	// Carry from the fraction accumulator stretches one feedback period.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ref_d_r <= 1'b0;
			rcnt_r <= 30'h0000_0000;
			fcnt_r <= 21'h00_0000;
			facc_r <= 10'h000;
			time_r <= 32'h0000_0000;
			tref_r <= 32'h0000_0000;
			ref_pulse_r <= 1'b0;
		end else begin
			ref_d_r <= ref_in[active_ref];
			time_r <= time_r + 32'h0000_0001;
			ref_pulse_r <= 1'b0;
			if (ref_rise) begin
				if (rcnt_r >= rdiv_r[act_prof]) begin
					rcnt_r <= 30'h0000_0000;
					tref_r <= time_r;
					ref_pulse_r <= 1'b1;
				end else begin
					rcnt_r <= rcnt_r + 30'h0000_0001;
				end
			end
			if (synth_tick) begin
				if (fb_pulse) begin
					fcnt_r <= 21'h00_0000;
					facc_r <= fcarry ? facc_sum[9:0] - v_r[act_prof] : facc_sum[9:0];
				end else begin
					fcnt_r <= fcnt_r + 21'h00_0001;
				end
			end
		end
	end

	// Phase error in units of 1/V cycle, with the fractional residue removed.
	wire [31:0] diff = tref_r - time_r;
	wire [42:0] scaled = $signed(diff) * $signed({1'b0, v_r[act_prof]});
	wire [ERR_W-1:0] comp = scaled[ERR_W-1:0] - {{(ERR_W-10){1'b0}}, facc_r};
	reg [ERR_W-1:0] pbo_off_r;
	reg pbo_pend_r;
	reg have_ref_r;
	wire [ERR_W-1:0] rel = comp - pbo_off_r;
	wire [ERR_W-1:0] lim = {{(ERR_W-16){1'b0}}, slew_rate_limit_r};
	wire rel_neg = rel[ERR_W-1];
	wire [ERR_W-1:0] rel_mag = rel_neg ? -rel : rel;
	wire slew_on = slewing_r && (slew_rate_limit_r != 16'h0000);
	wire [ERR_W-1:0] clamped = (slew_on && rel_mag > lim) ? (rel_neg ? -lim : lim) : rel;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pbo_off_r <= {ERR_W{1'b0}};
			pbo_pend_r <= 1'b0;
			slewing_r <= 1'b0;
			have_ref_r <= 1'b0;
			phase_err_word <= {ERR_W{1'b0}};
			phase_err_valid <= 1'b0;
			tune_word <= {ERR_W{1'b0}};
		end else begin
			phase_err_valid <= 1'b0;
			if (ref_pulse_r) begin
				have_ref_r <= 1'b1;
			end
			// A switch clears the reference history so stale samples are not compared.
			if (switch_pulse) begin
				pbo_pend_r <= buildout_pulse;
				if (!buildout_pulse) begin
					pbo_off_r <= {ERR_W{1'b0}};
				end
				slewing_r <= slew_rate_limit_r != 16'h0000;
				have_ref_r <= 1'b0;
			end else if (fb_pulse && have_ref_r && !holdover) begin
				if (pbo_pend_r) begin
					pbo_off_r <= comp;
					pbo_pend_r <= 1'b0;
				end else begin
					phase_err_word <= clamped;
					phase_err_valid <= 1'b1;
					tune_word <= tune_word + clamped;
					if (rel_mag <= lim) begin
						slewing_r <= 1'b0;
					end
				end
			end
		end
	end

endmodule

/* dv/prs_ref_src.sv */
// Purpose: Free running external reference clocks.
// Assumes: References are sampled into the system clock.
// Notes: Each reference runs at half the rate of the one before.
`timescale 1ns/1ps
module prs_ref_src #(
	parameter NREF = 4
) (
	// System
	input wire clk,
	input wire rst,
	// References
	output reg [NREF-1:0] ref_in
);
	reg [7:0] cnt_r;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 8'h00;
			ref_in <= {NREF{1'b0}};
		end else begin
			cnt_r <= cnt_r + 8'h01;
			ref_in <= cnt_r[NREF:1];
		end
	end
endmodule

/* dv/prs_switchover_assertions.sv */
// Purpose: Port checker for the reference switchover block.
// Assumes: One clock domain, asynchronous active high reset.
// Notes: Bound to the design at the foot of this file.
`timescale 1ns/1ps
`include "prs_consts.vh"
module prs_chk #(
	parameter NREF = 4,
	parameter NPROF = 8,
	parameter ERR_W = 32
) (
	// System
	input wire clk,
	input wire rst,
	// APB
	input wire [15:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	// References
	input wire [NREF-1:0] ref_valid,
	input wire [NREF-1:0] ref_assigned,
	input wire [3*NREF-1:0] ref_profile,
	// Loop and status
	input wire phase_err_valid,
	input wire [ERR_W-1:0] tune_word,
	input wire [1:0] active_ref,
	input wire holdover,
	input wire switch_pulse,
	input wire buildout_pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	reg [3:0] thr_r;
	reg [15:0] slew_r;
	wire wr_acc = psel && penable && pwrite;
	// Shadow copies of the threshold and slew limit.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			thr_r <= 4'h0;
			slew_r <= 16'h0000;
		end else if (wr_acc) begin
			if (paddr[15:2] == `PRS_IDX_PBO)
				thr_r <= pwdata[3:0];
			if (paddr[15:2] == `PRS_IDX_SLEW)
				slew_r <= pwdata[15:0];
		end
	end
	sw_cause_a: assert property (
		switch_pulse |-> !$stable({active_ref, holdover})) else $error("switch without change");
	bo_with_sw_a: assert property (
		buildout_pulse |-> switch_pulse) else $error("build-out without switch");
	thr_zero_bo_a: assert property (
		switch_pulse && thr_r == 4'h0 && $past(thr_r) == 4'h0 |-> buildout_pulse)
		else $error("no build-out at zero threshold");
	valid_act_a: assert property (
		!holdover |-> (($past(ref_valid & ref_assigned) >> active_ref) & 1) != 0)
		else $error("active reference not valid");
	stable_in_a: assert property (
		!psel ##1 (!psel && $stable(ref_valid) && $stable(ref_assigned) && $stable(ref_profile))
		|=> !switch_pulse) else $error("switch with stable inputs");
	pev_pulse_a: assert property (
		phase_err_valid |=> !phase_err_valid) else $error("error valid too long");
	tune_src_a: assert property (
		!$stable(tune_word) |-> phase_err_valid || $past(phase_err_valid))
		else $error("tuning word moved without error word");
	slew_rd_a: assert property (
		psel && penable && !pwrite && paddr[15:2] == `PRS_IDX_SLEW |-> prdata == {16'h0000, slew_r})
		else $error("slew limit readback wrong");
endmodule
bind prs_switchover prs_chk #(.NREF(NREF), .NPROF(NPROF), .ERR_W(ERR_W)) prs_chk_inst (
	.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .prdata(prdata), .ref_valid(ref_valid), .ref_assigned(ref_assigned),
	.ref_profile(ref_profile), .phase_err_valid(phase_err_valid), .tune_word(tune_word),
	.active_ref(active_ref), .holdover(holdover), .switch_pulse(switch_pulse),
	.buildout_pulse(buildout_pulse));

/* dv/tb_prs_switchover.sv */
// Purpose: Self-checking bench for the reference switchover block.
// Assumes: Zero wait state APB slave, 25 MHz clock.
// Notes: Expected results are queued by the driver and checked by the monitor.
`timescale 1ns/1ps
`include "prs_consts.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
	$display("mismatch at %0t got %h exp %h", $time, g, e); end end
module tb_prs_switchover;
	localparam [32:0] Z = 33'h0_0000_0000;
	reg clk = 0;
	reg rst = 1;
	reg [15:0] paddr = 16'h0000;
	reg psel = 0, penable = 0, pwrite = 0, synth_tick = 0;
	reg [31:0] pwdata = 32'h0000_0000;
	reg [3:0] ref_valid = 4'h0, ref_assigned = 4'hF;
	reg [11:0] ref_profile = 12'h488;
	wire [31:0] prdata, phase_err_word, tune_word;
	wire pready, pslverr, phase_err_valid, holdover, switch_pulse, buildout_pulse;
	wire [1:0] active_ref;
	wire [3:0] ref_in;
	int err_count = 0, check_count = 0, cyc = 0, pev_n = 0;
	reg [15:0] lfsr = 16'h0004;
	reg [32:0] rdq[$];
	reg [3:0] swq[$];
	reg [32:0] exp_rd;
	reg [3:0] exp_sw;
	always #20 clk = ~clk;
	prs_ref_src prs_ref_src_inst (.clk(clk), .rst(rst), .ref_in(ref_in));
	prs_switchover prs_switchover_inst (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ref_in(ref_in), .ref_valid(ref_valid), .ref_assigned(ref_assigned),
		.ref_profile(ref_profile), .synth_tick(synth_tick), .phase_err_word(phase_err_word),
		.phase_err_valid(phase_err_valid), .tune_word(tune_word), .active_ref(active_ref),
		.holdover(holdover), .switch_pulse(switch_pulse), .buildout_pulse(buildout_pulse));
	function automatic [15:0] lfsr_next(input [15:0] s);
		lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task give_verdict;
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task apb(input [13:0] idx, input wr, input [31:0] wd, input [32:0] exp);
		@(posedge clk);
		psel <= 1;
		paddr <= {idx, 2'b00};
		pwrite <= wr;
		pwdata <= wd;
		if (!wr)
			rdq.push_back(exp);
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel <= 0;
		penable <= 0;
	endtask
	// Bit 4 of e says a switch is due; bits 3:0 are holdover, reference and build-out.
	task step(input [3:0] v, input [3:0] a, input [4:0] e);
		@(posedge clk);
		ref_valid <= v;
		ref_assigned <= a;
		if (e[4])
			swq.push_back(e[3:0]);
		repeat (6) @(posedge clk);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		synth_tick <= (cyc % 4 == 0);
		if (phase_err_valid === 1'b1)
			pev_n <= pev_n + 1;
		if (psel && penable && pready && !pwrite) begin
			exp_rd = rdq.pop_front();
			`CHK({pslverr, prdata}, exp_rd)
		end
		if (switch_pulse === 1'b1) begin
			`CHK(swq.size() != 0, 1'b1)
			if (swq.size() != 0) begin
				exp_sw = swq.pop_front();
				`CHK({holdover, active_ref, buildout_pulse}, exp_sw)
			end
		end
		if (cyc == 3000) begin
			err_count++;
			give_verdict;
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 0;
		apb(`PRS_IDX_SLEW, 0, 0, Z);
		apb(`PRS_IDX_PBO, 0, 0, Z);
		apb(14'h0001, 0, 0, 33'h1_0000_0000);
		lfsr = lfsr_next(lfsr);
		apb(`PRS_IDX_SLEW, 1, {~lfsr, lfsr}, Z);
		apb(`PRS_IDX_SLEW, 0, 0, {17'h0_0000, lfsr});
		apb(`PRS_IDX_SLEW, 1, 32'h0000_0000, Z);
		// Higher index carries the better priority of inputs 0 and 1; inputs 2 and 3 share one profile and tie.
		apb(`PRS_IDX_PRIO, 1, 32'h0000_0013, Z);
		apb(`PRS_IDX_PRIO + 14'h0001, 1, 32'h0000_0022, Z);
		apb(`PRS_IDX_PRIO + 14'h0002, 1, 32'h0000_0055, Z);
		step(4'hC, 4'hF, 5'h15);
		apb(`PRS_IDX_PBO, 1, 32'h0000_0003, Z);
		step(4'hD, 4'hF, 5'h11);
		step(4'hF, 4'hF, 5'h00);
		step(4'hE, 4'hF, 5'h12);
		step(4'hE, 4'hD, 5'h15);
		swq.push_back(4'h7);
		apb(`PRS_IDX_CTRL, 1, 32'h0000_000B, Z);
		step(4'h6, 4'hD, 5'h15);
		repeat (300) @(posedge clk);
		`CHK(pev_n != 0, 1'b1)
		`CHK(swq.size(), 0)
		give_verdict;
	end
endmodule

/* include/prs_consts.vh */
// Purpose: Constants for the reference switchover and divider block.
// Assumes: Register offsets are word indices; byte address is four times the index.
// Notes: All widths and reset values of the register map live here.
`ifndef PRS_CONSTS_VH
`define PRS_CONSTS_VH

`define PRS_IDX_W 14
`define PRS_IDX_SLEW 14'h0316
`define PRS_IDX_PBO 14'h0507
`define PRS_IDX_CTRL 14'h0A01
`define PRS_IDX_STAT 14'h0D00
`define PRS_IDX_PRIO 14'h0600
`define PRS_IDX_RDIV 14'h0610
`define PRS_IDX_SDIV 14'h0620
`define PRS_IDX_FRAC 14'h0630
`define PRS_PROF_MASK 14'h3FF8

`define PRS_SLEW_RST 16'h0000
`define PRS_PBO_RST 4'h0
`define PRS_CTRL_RST 4'h0
`define PRS_PRIO_RST 3'h0
`define PRS_RDIV_RST 30'h0000_0000
`define PRS_SDIV_RST 20'h0_0007
`define PRS_U_RST 10'h000
`define PRS_V_RST 10'h001

`define PRS_MODE_AUTO 2'b00
`define PRS_MODE_FALLBACK 2'b01
`define PRS_MODE_HOLDOVER 2'b10
`define PRS_MODE_MANUAL 2'b11

`define PRS_CTRL_MODE_LSB 3
`define PRS_PRIO_SEL_LSB 0
`define PRS_PRIO_PROM_LSB 4
`define PRS_FRAC_V_LSB 16

`endif
